// ===== common/mpwm_pkg.sv
// What this block does
// - unit clock enable set: unit runs, registers writable, all channels stopped.
// - unit clock enable cleared: unit stops, all unit registers return to reset.
// - prescaler defines two operating clocks; each mode register picks one.
// - slave output enable and output mode 1: count operation drives the pin, not software.
// - port latch and direction cleared: pin shows the software output level.
// - master and slave start triggers written together; they self-clear.
// - start sets enable status, loads master counter from period, counts down.
// - master reaching zero raises interrupt and reloads in the same cycle.
// - every master interrupt loads each running slave counter from its duty data.
// - slave output with nonzero duty goes active one count clock after the master interrupt; zero duty makes it inactive.
// - slave goes inactive at zero, then holds all-ones until next trigger.
// - all counters are readable at any time, also while counting.
// - stop triggers written together clear enable status and freeze counters.
// - stop leaves slave pins at their present levels.
// - polarity 0 gives active-high output, polarity 1 active-low.
// - duty above period plus one simply gives a permanently active output.
package mpwm_pkg;
  localparam int ADDR_W = 20;
  localparam int CNT_W = 16;
  localparam int NCH = 3;
  localparam int NSLV = 2;
  // register byte addresses
  localparam logic [19:0] CLK_GATE_ADDR = 20'hf00f0;
  localparam logic [19:0] PRESCALER_ADDR = 20'h00000;
  localparam logic [19:0] MODE0_ADDR = 20'h00004;
  localparam logic [19:0] MODE1_ADDR = 20'h00008;
  localparam logic [19:0] MODE2_ADDR = 20'h0000c;
  localparam logic [19:0] DATA0_ADDR = 20'h00010;
  localparam logic [19:0] DATA1_ADDR = 20'h00014;
  localparam logic [19:0] DATA2_ADDR = 20'h00018;
  localparam logic [19:0] COUNT0_ADDR = 20'h0001c;
  localparam logic [19:0] COUNT1_ADDR = 20'h00020;
  localparam logic [19:0] COUNT2_ADDR = 20'h00024;
  localparam logic [19:0] OUT_MODE_ADDR = 20'h00028;
  localparam logic [19:0] POLARITY_ADDR = 20'h0002c;
  localparam logic [19:0] OUT_ENABLE_ADDR = 20'h00030;
  localparam logic [19:0] OUT_LEVEL_ADDR = 20'h00034;
  localparam logic [19:0] START_ADDR = 20'h00038;
  localparam logic [19:0] STOP_ADDR = 20'h0003c;
  localparam logic [19:0] STATUS_ADDR = 20'h00040;
  localparam logic [19:0] PORT_LATCH_ADDR = 20'h00044;
  localparam logic [19:0] PORT_DIR_ADDR = 20'h00048;
  // field positions
  localparam int UNIT_EN_BIT = 0;
  localparam int MODE_CKSEL_BIT = 0;
  localparam int PSC_A_LSB = 0;
  localparam int PSC_B_LSB = 4;
  // reset values
  localparam logic [7:0] CLK_GATE_RST = 8'h00;
  localparam logic [7:0] PRESCALER_RST = 8'h00;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'hffff;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_HALT = 16'hffff;
  localparam logic [2:0] CH_BITS_RST = 3'h0;
  localparam logic [2:0] PORT_DIR_RST = 3'h7;
endpackage

// ===== hw/mpwm_slave_channel.sv
`timescale 1ns/1ps
`default_nettype none
module mpwm_slave_channel
  import mpwm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic unit_clear,
  input wire logic run,
  input wire logic tick,
  input wire logic trigger,
  input wire logic [15:0] duty,
  output logic [15:0] count,
  output logic set_active,
  output logic set_inactive
);
  logic pending;
  logic [15:0] next_count;
  logic load;
  logic dec;
  logic wrap;

  // ---------------------------------------------------------------
  // one-count sequencing
  // ---------------------------------------------------------------
  assign next_count = count - 16'h0001;
  assign load = run & tick & pending;
  assign dec = run & tick & ~pending & (count != COUNT_ZERO)
    & (count != COUNT_HALT);
  assign wrap = run & tick & ~pending & (count == COUNT_ZERO);
  assign set_active = load & (duty != COUNT_ZERO);
  assign set_inactive = (load & (duty == COUNT_ZERO))
    | (dec & (next_count == COUNT_ZERO));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending <= 1'b0;
    end else if (unit_clear) begin
      pending <= 1'b0;
    end else if (run & trigger) begin
      pending <= 1'b1;
    end else if (run & tick) begin
      pending <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= COUNT_RST;
    end else if (unit_clear) begin
      count <= COUNT_RST;
    end else if (load) begin
      count <= duty;
    end else if (dec) begin
      count <= next_count;
    end else if (wrap) begin
      count <= COUNT_HALT;
    end
  end
endmodule
`default_nettype wire

// ===== hw/mpwm_top.sv
`timescale 1ns/1ps
`default_nettype none
module mpwm_top
  import mpwm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [19:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic slave1_pwm_pin,
  output logic slave1_pwm_pin_oe,
  output logic slave2_pwm_pin,
  output logic slave2_pwm_pin_oe,
  output logic master_period_interrupt
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] peripheral_clock_gate;
  logic [7:0] timer_prescaler_select;
  logic [15:0] mode_reg [NCH];
  logic [15:0] data_reg [NCH];
  logic [2:0] output_mode_select;
  logic [2:0] output_polarity_select;
  logic [2:0] count_output_enable;
  logic [2:0] output_level_bits;
  logic [2:0] channel_enable_status;
  logic [2:0] port_latch;
  logic [2:0] port_dir;
  logic [15:0] master_down_counter;
  logic [15:0] slave_count [NSLV];
  logic [15:0] prescale_cnt;
  logic [NSLV-1:0] slv_set;
  logic [NSLV-1:0] slv_clr;
  logic [2:0] pin_q;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire unit_en = peripheral_clock_gate[UNIT_EN_BIT];
  wire unit_clear = ~unit_en;
  wire setup = psel & ~penable;
  wire wr = psel & penable & pwrite;
  wire hit_gate = paddr == CLK_GATE_ADDR;
  wire hit_psc = paddr == PRESCALER_ADDR;
  wire hit_m0 = paddr == MODE0_ADDR;
  wire hit_m1 = paddr == MODE1_ADDR;
  wire hit_m2 = paddr == MODE2_ADDR;
  wire hit_d0 = paddr == DATA0_ADDR;
  wire hit_d1 = paddr == DATA1_ADDR;
  wire hit_d2 = paddr == DATA2_ADDR;
  wire hit_c0 = paddr == COUNT0_ADDR;
  wire hit_c1 = paddr == COUNT1_ADDR;
  wire hit_c2 = paddr == COUNT2_ADDR;
  wire hit_om = paddr == OUT_MODE_ADDR;
  wire hit_pol = paddr == POLARITY_ADDR;
  wire hit_oe = paddr == OUT_ENABLE_ADDR;
  wire hit_lvl = paddr == OUT_LEVEL_ADDR;
  wire hit_start = paddr == START_ADDR;
  wire hit_stop = paddr == STOP_ADDR;
  wire hit_stat = paddr == STATUS_ADDR;
  wire hit_pl = paddr == PORT_LATCH_ADDR;
  wire hit_pd = paddr == PORT_DIR_ADDR;
  wire mapped = hit_gate | hit_psc | hit_m0 | hit_m1 | hit_m2 | hit_d0
    | hit_d1 | hit_d2 | hit_c0 | hit_c1 | hit_c2 | hit_om | hit_pol
    | hit_oe | hit_lvl | hit_start | hit_stop | hit_stat | hit_pl | hit_pd;
  // unit registers take writes only while the unit clock runs
  wire wr_unit = wr & unit_en;
  wire [2:0] start_pulse = (wr_unit & hit_start) ? pwdata[2:0] : 3'h0;
  wire [2:0] stop_pulse = (wr_unit & hit_stop) ? pwdata[2:0] : 3'h0;

  wire [31:0] rd_mux =
      ({32{hit_gate}} & {24'h0, peripheral_clock_gate})
    | ({32{hit_psc}} & {24'h0, timer_prescaler_select})
    | ({32{hit_m0}} & {16'h0, mode_reg[0]})
    | ({32{hit_m1}} & {16'h0, mode_reg[1]})
    | ({32{hit_m2}} & {16'h0, mode_reg[2]})
    | ({32{hit_d0}} & {16'h0, data_reg[0]})
    | ({32{hit_d1}} & {16'h0, data_reg[1]})
    | ({32{hit_d2}} & {16'h0, data_reg[2]})
    | ({32{hit_c0}} & {16'h0, master_down_counter})
    | ({32{hit_c1}} & {16'h0, slave_count[0]})
    | ({32{hit_c2}} & {16'h0, slave_count[1]})
    | ({32{hit_om}} & {29'h0, output_mode_select})
    | ({32{hit_pol}} & {29'h0, output_polarity_select})
    | ({32{hit_oe}} & {29'h0, count_output_enable})
    | ({32{hit_lvl}} & {29'h0, output_level_bits})
    | ({32{hit_stat}} & {29'h0, channel_enable_status})
    | ({32{hit_pl}} & {29'h0, port_latch})
    | ({32{hit_pd}} & {29'h0, port_dir});

  assign pready = 1'b1;

  // read data and error are captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h00000000 : rd_mux;
      pslverr <= ~mapped;
    end
  end

  // ---------------------------------------------------------------
  // clock gate and configuration
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_clock_gate <= CLK_GATE_RST;
    end else if (wr & hit_gate) begin
      peripheral_clock_gate <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_prescaler_select <= PRESCALER_RST;
      output_mode_select <= CH_BITS_RST;
      output_polarity_select <= CH_BITS_RST;
      count_output_enable <= CH_BITS_RST;
    end else if (unit_clear) begin
      timer_prescaler_select <= PRESCALER_RST;
      output_mode_select <= CH_BITS_RST;
      output_polarity_select <= CH_BITS_RST;
      count_output_enable <= CH_BITS_RST;
    end else begin
      if (wr & hit_psc) begin
        timer_prescaler_select <= pwdata[7:0];
      end
      if (wr & hit_om) begin
        output_mode_select <= pwdata[2:0];
      end
      if (wr & hit_pol) begin
        output_polarity_select <= pwdata[2:0];
      end
      if (wr & hit_oe) begin
        count_output_enable <= pwdata[2:0];
      end
    end
  end

  // port latch and direction belong to the pin, not the timer unit:
  // gating the unit off leaves them, so a latched level survives it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_latch <= CH_BITS_RST;
      port_dir <= PORT_DIR_RST;
    end else begin
      if (wr & hit_pl) begin
        port_latch <= pwdata[2:0];
      end
      if (wr & hit_pd) begin
        port_dir <= pwdata[2:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // per-channel mode and data registers
  // ---------------------------------------------------------------
  wire [NCH-1:0] hit_mode = {hit_m2, hit_m1, hit_m0};
  wire [NCH-1:0] hit_data = {hit_d2, hit_d1, hit_d0};
  wire [NCH-1:0] tick;
  wire [15:0] mask_a = ~(16'hffff << timer_prescaler_select[PSC_A_LSB+:4]);
  wire [15:0] mask_b = ~(16'hffff << timer_prescaler_select[PSC_B_LSB+:4]);
  wire clk_a = (prescale_cnt & mask_a) == mask_a;
  wire clk_b = (prescale_cnt & mask_b) == mask_b;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      assign tick[gi] = mode_reg[gi][MODE_CKSEL_BIT] ? clk_b : clk_a;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mode_reg[gi] <= MODE_RST;
          data_reg[gi] <= DATA_RST;
        end else if (unit_clear) begin
          mode_reg[gi] <= MODE_RST;
          data_reg[gi] <= DATA_RST;
        end else begin
          if (wr & hit_mode[gi]) begin
            mode_reg[gi] <= pwdata[15:0];
          end
          if (wr & hit_data[gi]) begin
            data_reg[gi] <= pwdata[15:0];
          end
        end
      end
    end
  endgenerate

  // free-running prescaler, cleared to zero while the unit clock is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_cnt <= 16'h0000;
    end else if (unit_clear) begin
      prescale_cnt <= 16'h0000;
    end else begin
      prescale_cnt <= prescale_cnt + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // start, stop and enable status
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_enable_status <= CH_BITS_RST;
    end else if (unit_clear) begin
      channel_enable_status <= CH_BITS_RST;
    end else begin
      // triggers are pulses and never stored; status follows them
      channel_enable_status <= (channel_enable_status & ~stop_pulse)
        | start_pulse;
    end
  end

  // ---------------------------------------------------------------
  // master channel
  // ---------------------------------------------------------------
  wire master_run = channel_enable_status[0];
  wire master_hit = master_run & tick[0]
    & (master_down_counter == COUNT_ZERO);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_down_counter <= COUNT_RST;
    end else if (unit_clear) begin
      master_down_counter <= COUNT_RST;
    end else if (start_pulse[0]) begin
      master_down_counter <= data_reg[0];
    end else if (master_hit) begin
      master_down_counter <= data_reg[0];
    end else if (master_run & tick[0]) begin
      master_down_counter <= master_down_counter - 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_period_interrupt <= 1'b0;
    end else begin
      master_period_interrupt <= master_hit & ~start_pulse[0];
    end
  end

  // ---------------------------------------------------------------
  // slave channels
  // ---------------------------------------------------------------
  generate
    for (gi = 0; gi < NSLV; gi++) begin : g_slv
      mpwm_slave_channel u_slave (
        .pclk(pclk),
        .presetn(presetn),
        .unit_clear(unit_clear),
        .run(channel_enable_status[gi+1]),
        .tick(tick[gi+1]),
        .trigger(master_hit & ~start_pulse[0]),
        .duty(data_reg[gi+1]),
        .count(slave_count[gi]),
        .set_active(slv_set[gi]),
        .set_inactive(slv_clr[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // output level bits and pins
  // ---------------------------------------------------------------
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_out
      wire hw_drive;
      wire hw_set;
      wire hw_clr;
      if (gi == 0) begin : g_master
        assign hw_set = 1'b0;
        assign hw_clr = 1'b0;
      end else begin : g_slave
        assign hw_set = slv_set[gi-1];
        assign hw_clr = slv_clr[gi-1];
      end
      assign hw_drive = count_output_enable[gi]
        & output_mode_select[gi];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          output_level_bits[gi] <= 1'b0;
        end else if (unit_clear) begin
          output_level_bits[gi] <= 1'b0;
        end else if (hw_drive & hw_clr) begin
          // polarity 1 means active-low
          output_level_bits[gi] <= output_polarity_select[gi];
        end else if (hw_drive & hw_set) begin
          output_level_bits[gi] <= ~output_polarity_select[gi];
        end else if (~count_output_enable[gi] & wr & hit_lvl) begin
          output_level_bits[gi] <= pwdata[gi];
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_q[gi] <= 1'b0;
        end else begin
          pin_q[gi] <= output_level_bits[gi] | port_latch[gi];
        end
      end
    end
  endgenerate

  assign slave1_pwm_pin = pin_q[1];
  assign slave2_pwm_pin = pin_q[2];
  assign slave1_pwm_pin_oe = ~port_dir[1];
  assign slave2_pwm_pin_oe = ~port_dir[2];
endmodule
`default_nettype wire

// ===== verif/mpwm_props.sv
`timescale 1ns/1ps
`default_nettype none
module mpwm_props
  import mpwm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [19:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic slave1_pwm_pin,
  input wire logic slave1_pwm_pin_oe,
  input wire logic slave2_pwm_pin,
  input wire logic slave2_pwm_pin_oe,
  input wire logic master_period_interrupt
);
  logic gate_on;
  wire logic acc;
  wire logic rd_acc;
  wire logic unmapped;
  wire logic stop_all;
  assign acc = psel && penable;
  assign rd_acc = acc && !pwrite;
  assign unmapped = !(paddr == CLK_GATE_ADDR ||
                      (paddr <= PORT_DIR_ADDR && paddr[1:0] == 2'h0));
  assign stop_all = acc && pwrite && paddr == STOP_ADDR &&
                    pwdata[2:0] == 3'h7;
  // shadow of the unit clock gate bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_on <= 1'b0;
    end else if (acc && pwrite && paddr == CLK_GATE_ADDR) begin
      gate_on <= pwdata[0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_high: assert property (pready)
    else $error("pready low");
  a_unmapped_err: assert property (acc |-> pslverr == unmapped)
    else $error("pslverr does not match address map");
  a_oe_reset_low: assert property
    ($rose(presetn) |-> !slave1_pwm_pin_oe && !slave2_pwm_pin_oe)
    else $error("pin driven after reset");
  a_irq_single: assert property
    (master_period_interrupt |=> !master_period_interrupt)
    else $error("interrupt longer than one cycle");
  a_stop_quiet: assert property
    (stop_all |=> ##1 !master_period_interrupt [*8])
    else $error("interrupt after stop");
  a_stop_hold: assert property
    (stop_all |=> ##2 ($stable(slave1_pwm_pin) && $stable(slave2_pwm_pin))
     [*8])
    else $error("pin moved after stop");
  a_trigger_read_zero: assert property
    (rd_acc && (paddr == START_ADDR || paddr == STOP_ADDR) |->
     prdata == 32'h0)
    else $error("trigger register reads nonzero");
  a_upper_zero: assert property (rd_acc |-> prdata[31:16] == 16'h0)
    else $error("upper read bits set");
  a_gated_count: assert property
    (rd_acc && !gate_on && paddr == COUNT0_ADDR |->
     prdata == 32'h0000ffff)
    else $error("gated counter read not reset value");
  c_irq: cover property (master_period_interrupt);
  c_stop: cover property (stop_all);
  c_unmapped: cover property (acc && unmapped);
endmodule
bind mpwm_top mpwm_props mpwm_props_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .slave1_pwm_pin(slave1_pwm_pin), .slave1_pwm_pin_oe(slave1_pwm_pin_oe),
  .slave2_pwm_pin(slave2_pwm_pin), .slave2_pwm_pin_oe(slave2_pwm_pin_oe),
  .master_period_interrupt(master_period_interrupt));
`default_nettype wire

// ===== verif/mpwm_pin_load.sv
`timescale 1ns/1ps
`default_nettype none
module mpwm_pin_load (
  input wire logic pclk,
  input wire logic clear,
  input wire logic pin1,
  input wire logic oe1,
  input wire logic pin2,
  input wire logic oe2,
  output logic [15:0] high1,
  output logic [15:0] high2
);
  // undriven lines fall to the pull-down level
  wire logic line1;
  wire logic line2;
  assign line1 = oe1 ? pin1 : 1'b0;
  assign line2 = oe2 ? pin2 : 1'b0;
  // counts clock samples with each line high since the last clear
  always @(posedge pclk) begin
    if (clear) begin
      high1 <= {15'h0, line1};
      high2 <= {15'h0, line2};
    end else begin
      high1 <= high1 + {15'h0, line1};
      high2 <= high2 + {15'h0, line2};
    end
  end
endmodule
`default_nettype wire

// ===== verif/multi_pwm_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module multi_pwm_timer_test;
  import mpwm_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, clr, err;
  logic [19:0] paddr;
  logic [31:0] pwdata, rd, keep;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, pin1, oe1, pin2, oe2, irq;
  wire logic [15:0] high1, high2;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  mpwm_top mpwm_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slave1_pwm_pin(pin1), .slave1_pwm_pin_oe(oe1),
    .slave2_pwm_pin(pin2), .slave2_pwm_pin_oe(oe2),
    .master_period_interrupt(irq));
  mpwm_pin_load mpwm_pin_load_inst (.pclk(pclk), .clear(clr), .pin1(pin1),
    .oe1(oe1), .pin2(pin2), .oe2(oe2), .high1(high1), .high2(high2));
  // ----------------------------------------
  // clock, timeout and verdict
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic report_and_stop();
    $display("counts: checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      $display("unexpected at %0t: timeout", $time);
      report_and_stop();
    end
  end
  // ----------------------------------------
  // bus and measurement tasks
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [19:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [19:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic wait_irq(output int k);
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (irq !== 1'b1 && k < 100);
  endtask
  // counts pin high samples over three periods from an interrupt edge
  task automatic measure(input logic [15:0] e1, input logic [15:0] e2);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (3) wait_irq(n);
    @(posedge pclk);
    `CHK(high1, e1)
    `CHK(high2, e2)
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 20'h0;
    pwdata = 32'h0;
    clr = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(CLK_GATE_ADDR, 32'h0);
    rdchk(COUNT0_ADDR, 32'h0000ffff);
    wr(DATA0_ADDR, 32'h5);
    wr(CLK_GATE_ADDR, 32'h1);
    rdchk(DATA0_ADDR, 32'h0);
    rdchk(STATUS_ADDR, 32'h0);
    apb(1'b0, 20'h00100, 32'h0);
    `CHK(err, 1'b1)
    `CHK({oe1, oe2}, 2'b00)
    $display("test gate done");
    wr(PORT_DIR_ADDR, 32'h0);
    wr(OUT_LEVEL_ADDR, 32'h2);
    repeat (2) @(posedge pclk);
    `CHK({oe1, oe2, pin1, pin2}, 4'b1110)
    $display("test level done");
    wr(PRESCALER_ADDR, 32'h10);
    for (int i = 0; i < 3; i++) wr(MODE0_ADDR + 20'(4 * i), 32'h1);
    wr(DATA0_ADDR, 32'h5);
    wr(DATA1_ADDR, 32'ha);
    wr(DATA2_ADDR, 32'h2);
    wr(OUT_MODE_ADDR, 32'h6);
    wr(POLARITY_ADDR, 32'h4);
    wr(OUT_LEVEL_ADDR, 32'h4);
    wr(OUT_ENABLE_ADDR, 32'h6);
    wr(START_ADDR, 32'h7);
    rdchk(STATUS_ADDR, 32'h7);
    rdchk(START_ADDR, 32'h0);
    apb(1'b0, COUNT0_ADDR, 32'h0);
    `CHK(rd <= 32'h5, 1'b1)
    wait_irq(n);
    wait_irq(n);
    `CHK(n, 12)
    measure(16'd36, 16'd24);
    wr(DATA1_ADDR, 32'h2);
    wait_irq(n);
    wait_irq(n);
    measure(16'd12, 16'd24);
    $display("test run done");
    wr(STOP_ADDR, 32'h7);
    repeat (2) @(posedge pclk);
    keep = {30'h0, pin1, pin2};
    repeat (8) @(posedge pclk);
    `CHK({30'h0, pin1, pin2}, keep)
    rdchk(STATUS_ADDR, 32'h0);
    apb(1'b0, COUNT0_ADDR, 32'h0);
    keep = rd;
    repeat (6) @(posedge pclk);
    rdchk(COUNT0_ADDR, keep);
    $display("test stop done");
    wr(OUT_ENABLE_ADDR, 32'h0);
    wr(PORT_LATCH_ADDR, 32'h6);
    wr(OUT_LEVEL_ADDR, 32'h0);
    repeat (2) @(posedge pclk);
    `CHK({pin1, pin2}, 2'b11)
    wr(CLK_GATE_ADDR, 32'h0);
    repeat (2) @(posedge pclk);
    `CHK({pin1, pin2}, 2'b11)
    wr(CLK_GATE_ADDR, 32'h1);
    rdchk(DATA0_ADDR, 32'h0);
    rdchk(COUNT0_ADDR, 32'h0000ffff);
    rdchk(POLARITY_ADDR, 32'h0);
    rdchk(PORT_DIR_ADDR, 32'h0);
    $display("test gate off done");
    // reset modes pick clock a, reset prescaler ticks it every cycle
    wr(PORT_LATCH_ADDR, 32'h0);
    wr(DATA0_ADDR, 32'h3);
    wr(DATA1_ADDR, 32'h0);
    wr(DATA2_ADDR, 32'h4);
    wr(OUT_MODE_ADDR, 32'h6);
    wr(OUT_ENABLE_ADDR, 32'h6);
    wr(START_ADDR, 32'h7);
    wait_irq(n);
    wait_irq(n);
    `CHK(n, 4)
    measure(16'd0, 16'd12);
    $display("test fast clock done");
    report_and_stop();
  end
endmodule
`default_nettype wire
